// ==== inc/was_pkg.sv ====
package was_pkg;
  // ==========================================================================
  // wavefront shape and issue timing
  localparam int WAVE_ITEMS      = 64;
  localparam int QUARTERS        = 4;
  localparam int LANES           = WAVE_ITEMS / QUARTERS;
  localparam int ALU_LATENCY_CYC = 8;
  localparam int MEM_LAT_MIN_CYC = 300;
  localparam int MEM_LAT_MAX_CYC = 600;
  // ==========================================================================
  // residency limits
  localparam int MAX_GROUPS        = 8;
  localparam int MAX_WG_ITEMS      = 256;
  localparam int MAX_WG_WAVES      = MAX_WG_ITEMS / WAVE_ITEMS;
  localparam int MAX_WAVES         = MAX_GROUPS * MAX_WG_WAVES;
  localparam int GLOBAL_WAVE_LIMIT = 496;
  localparam int CHIP_UNITS        = 20;
  // ==========================================================================
  // register pool and local share memory
  localparam int POOL_REGS    = 16384;
  localparam int REG_ELEMS    = 4;
  localparam int REG_ELEM_W   = 32;
  localparam int REG_RESERVED = 512;
  localparam int ROW_CAP      = (POOL_REGS - REG_RESERVED) / WAVE_ITEMS;
  localparam int CLAUSE_TEMPS = 4;
  localparam int LOCAL_BYTES  = 32768;
  // ==========================================================================
  // field widths
  localparam int SLOT_W  = 5;
  localparam int GRP_W   = 3;
  localparam int TIMER_W = 3;
  localparam int WAVES_W = 3;
  localparam int ROWS_W  = 8;
  localparam int LOC_W   = 16;
  localparam int CHIP_W  = 10;
  localparam int CNT_W   = 6;
  localparam int GCNT_W  = 4;
  localparam logic [TIMER_W-1:0] TIMER_LOAD   = TIMER_W'(ALU_LATENCY_CYC - 1);
  localparam logic [1:0]         LAST_QUARTER = 2'(QUARTERS - 1);
  // ==========================================================================
  // instruction kinds reported for a starting burst
  typedef enum logic [1:0] {KIND_ALU, KIND_MEM_READ, KIND_END} was_kind_type;
endpackage : was_pkg

// ==== inc/was_adm_if.sv ====
`timescale 1ns/1ns
interface was_adm_if;
  import was_pkg::*;
  logic [GCNT_W-1:0] groupCount;
  logic [CNT_W-1:0]  ownWaves;
  logic [ROWS_W:0]   usedRows;
  logic [LOC_W-1:0]  usedLoc;
  logic [WAVES_W-1:0] reqWaves;
  logic [ROWS_W-1:0] reqRegs;
  logic [LOC_W-1:0]  reqLoc;
  logic [CHIP_W-1:0] otherWaves;
  logic              fits;
  logic [ROWS_W-1:0] rowsPerWave;
  modport ctrl (output groupCount, ownWaves, usedRows, usedLoc, reqWaves,
                output reqRegs, reqLoc, otherWaves, input fits, rowsPerWave);
  modport check (input groupCount, ownWaves, usedRows, usedLoc, reqWaves,
                 input reqRegs, reqLoc, otherWaves, output fits, rowsPerWave);
endinterface : was_adm_if

// ==== verilog/was_admission.sv ====
`timescale 1ns/1ns
module was_admission #(
  parameter int GLOBAL_LIMIT = was_pkg::GLOBAL_WAVE_LIMIT
) (
  // limit check
  was_adm_if.check adm
);
  import was_pkg::*;

  logic [ROWS_W-1:0] rows;
  logic [11:0]       needRows;
  logic [10:0]       chipWaves;
  logic [16:0]       locTotal;
  logic              groupsOk;
  logic              wavesOk;

  // ==========================================================================
  // per-limit checks
  always_comb begin
    rows = (adm.reqRegs == 8'h00) ? 8'h01 : adm.reqRegs;
    needRows = 12'(adm.usedRows) + 12'(rows) * 12'(adm.reqWaves);
    chipWaves = 11'(adm.otherWaves) + 11'(adm.ownWaves) + 11'(adm.reqWaves);
    locTotal = 17'(adm.usedLoc) + 17'(adm.reqLoc);
    groupsOk = adm.groupCount < GCNT_W'(MAX_GROUPS);
    wavesOk = (adm.reqWaves != 3'h0) && (adm.reqWaves <= 3'(MAX_WG_WAVES));
  end

  // ==========================================================================
  // all limits must hold after admission
  assign adm.fits = groupsOk && wavesOk
                 && (chipWaves <= 11'(GLOBAL_LIMIT))
                 && (needRows <= 12'(ROW_CAP))
                 && (locTotal <= 17'(LOCAL_BYTES));
  assign adm.rowsPerWave = rows;
endmodule : was_admission

// ==== verilog/was_scheduler.sv ====
`timescale 1ns/1ns
// How it works
// - a wavefront is 64 items over four cycles
// - sixteen lanes issue each cycle, one quarter
// - dependent issue waits eight cycles after issue
// - switch to another ready wavefront after four cycles
// - memory read parks wavefront until its response
// - keep issuing other ready wavefronts meanwhile
// - at most eight resident work-groups
// - work-group up to four wavefronts, 32 resident
// - chip-wide active wavefront ceiling refuses admission
// - pool of 16384 four-element 32-bit registers
// - registers allocated per wavefront, returned at end
// - admission stops when pool cannot fit wavefronts
// - thirty registers per item allows eight wavefronts
// - four clause temporaries outside pool accounting
// - 32k local share memory bounds admission
module was_scheduler #(
  parameter int GLOBAL_LIMIT = was_pkg::GLOBAL_WAVE_LIMIT,
  parameter int WG_ID_W      = 8
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             reset_n,
  // work-group admission
  input  wire logic                             wgValid,
  output wire logic                             wgReady,
  input  wire logic [was_pkg::WAVES_W-1:0]      wgWaves,
  input  wire logic [was_pkg::ROWS_W-1:0]       wgRegs,
  input  wire logic [was_pkg::LOC_W-1:0]        wgLocalBytes,
  input  wire logic [WG_ID_W-1:0]               wgId,
  input  wire logic [was_pkg::CHIP_W-1:0]       otherWaves,
  // work-group completion
  output logic                                  wgDoneValid,
  output logic      [WG_ID_W-1:0]               wgDoneId,
  // issue
  output logic                                  issueValid,
  output logic                                  issueStart,
  output logic      [was_pkg::SLOT_W-1:0]       issueSlot,
  output logic      [1:0]                       issueQuarter,
  output wire logic [5:0]                       issueLaneBase,
  output wire logic [was_pkg::LANES-1:0]        issueLaneMask,
  output logic      [was_pkg::ROWS_W-1:0]       issueRegRows,
  output logic      [was_pkg::SLOT_W+1:0]       issueTempBase,
  input  wire was_pkg::was_kind_type            instKind,
  // global memory path
  output logic                                  memReqValid,
  output logic      [was_pkg::SLOT_W-1:0]       memReqSlot,
  input  wire logic                             memRespValid,
  input  wire logic [was_pkg::SLOT_W-1:0]       memRespSlot,
  // occupancy
  output wire logic [was_pkg::CNT_W-1:0]        activeWaves,
  output wire logic [was_pkg::GCNT_W-1:0]       residentGroups
);
  import was_pkg::*;

  typedef enum logic {ST_IDLE, ST_BURST} was_state_type;

  // ==========================================================================
  // helpers
  function automatic logic [SLOT_W:0] pickNext(
    input logic [MAX_WAVES-1:0] elig,
    input logic [SLOT_W-1:0]    from);
    logic [SLOT_W:0]   res;
    logic [SLOT_W-1:0] idx;
    res = '0;
    for (int k = MAX_WAVES; k >= 1; k--) begin
      idx = from + SLOT_W'(k);
      if (elig[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : pickNext

  function automatic logic [GRP_W-1:0] firstFree(input logic [MAX_GROUPS-1:0] used);
    logic [GRP_W-1:0] res;
    res = '0;
    for (int k = MAX_GROUPS - 1; k >= 0; k--) begin
      if (!used[k]) begin
        res = GRP_W'(k);
      end
    end
    return res;
  endfunction : firstFree

  // ==========================================================================
  // tables and counters
  logic [MAX_GROUPS-1:0] grpValid;
  logic [WAVES_W-1:0]    grpLeft  [MAX_GROUPS];
  logic [LOC_W-1:0]      grpLoc   [MAX_GROUPS];
  logic [ROWS_W-1:0]     grpRows  [MAX_GROUPS];
  logic [WG_ID_W-1:0]    grpId    [MAX_GROUPS];
  logic [MAX_WAVES-1:0]  waveValid;
  logic [MAX_WAVES-1:0]  waveParked;
  logic [TIMER_W-1:0]    waveTimer[MAX_WAVES];
  logic [GRP_W-1:0]      waveGroup[MAX_WAVES];
  logic [GCNT_W-1:0]     groupCount;
  logic [CNT_W-1:0]      waveCount;
  logic [ROWS_W:0]       usedRows;
  logic [LOC_W-1:0]      usedLoc;
  logic [GCNT_W-1:0]     next_groupCount;
  logic [CNT_W-1:0]      next_waveCount;
  logic [ROWS_W:0]       next_usedRows;
  logic [LOC_W-1:0]      next_usedLoc;

  // issue state
  was_state_type         state;
  was_kind_type          curKind;
  logic [SLOT_W-1:0]     curSlot;

  // combinational decisions
  logic                  admit;
  logic [GRP_W-1:0]      newGroup;
  logic [MAX_WAVES-1:0]  newWave;
  logic [WAVES_W-1:0]    taken;
  logic [MAX_WAVES-1:0]  elig;
  logic [SLOT_W:0]       pick;
  logic                  advance;
  logic                  lastQuarter;
  logic                  waveEnd;
  logic                  memPark;
  logic [GRP_W-1:0]      endGroup;
  logic                  groupDone;

  // ==========================================================================
  // admission check
  was_adm_if adm ();

  assign adm.groupCount = groupCount;
  assign adm.ownWaves   = waveCount;
  assign adm.usedRows   = usedRows;
  assign adm.usedLoc    = usedLoc;
  assign adm.reqWaves   = wgWaves;
  assign adm.reqRegs    = wgRegs;
  assign adm.reqLoc     = wgLocalBytes;
  assign adm.otherWaves = otherWaves;

  was_admission #(
    .GLOBAL_LIMIT (GLOBAL_LIMIT)
  ) u_admission (
    .adm (adm)
  );

  assign wgReady = adm.fits;
  assign admit   = wgValid && adm.fits;

  // ==========================================================================
  // slot allocation for an admitted group
  always_comb begin
    newGroup = firstFree(grpValid);
    newWave  = '0;
    taken    = '0;
    for (int i = 0; i < MAX_WAVES; i++) begin
      if (admit && !waveValid[i] && (taken < wgWaves)) begin
        newWave[i] = 1'b1;
        taken      = taken + 3'h1;
      end
    end
  end

  // ==========================================================================
  // issue selection and burst events
  assign lastQuarter = (state == ST_BURST) && (issueQuarter == LAST_QUARTER);
  assign advance     = (state == ST_IDLE) || lastQuarter;
  assign waveEnd     = lastQuarter && (curKind == KIND_END);
  assign memPark     = lastQuarter && (curKind == KIND_MEM_READ);
  assign endGroup    = waveGroup[curSlot];
  assign groupDone   = waveEnd && (grpLeft[endGroup] == 3'h1);

  always_comb begin
    for (int i = 0; i < MAX_WAVES; i++) begin
      elig[i] = waveValid[i] && !waveParked[i]
             && (waveTimer[i] <= TIMER_W'(1));
    end
    pick = pickNext(elig, curSlot);
  end

  // ==========================================================================
  // occupancy accounting
  always_comb begin
    next_groupCount = groupCount + GCNT_W'(admit) - GCNT_W'(groupDone);
    next_waveCount  = waveCount + (admit ? CNT_W'(wgWaves) : 6'h00)
                    - CNT_W'(waveEnd);
    next_usedRows   = usedRows
                    + (admit ? 9'(adm.rowsPerWave * 9'(wgWaves)) : 9'h000)
                    - (waveEnd ? 9'(grpRows[endGroup]) : 9'h000);
    next_usedLoc    = usedLoc + (admit ? wgLocalBytes : 16'h0000)
                    - (groupDone ? grpLoc[endGroup] : 16'h0000);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      groupCount <= '0;
      waveCount  <= '0;
      usedRows   <= '0;
      usedLoc    <= '0;
    end else begin
      groupCount <= next_groupCount;
      waveCount  <= next_waveCount;
      usedRows   <= next_usedRows;
      usedLoc    <= next_usedLoc;
    end
  end

  assign activeWaves    = waveCount;
  assign residentGroups = groupCount;

  // ==========================================================================
  // work-group table
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      grpValid <= '0;
      for (int g = 0; g < MAX_GROUPS; g++) begin
        grpLeft[g] <= '0;
        grpLoc[g]  <= '0;
        grpRows[g] <= '0;
        grpId[g]   <= '0;
      end
    end else begin
      if (waveEnd) begin
        grpLeft[endGroup] <= grpLeft[endGroup] - 3'h1;
      end
      if (groupDone) begin
        grpValid[endGroup] <= 1'b0;
      end
      if (admit) begin
        grpValid[newGroup] <= 1'b1;
        grpLeft[newGroup]  <= wgWaves;
        grpLoc[newGroup]   <= wgLocalBytes;
        grpRows[newGroup]  <= adm.rowsPerWave;
        grpId[newGroup]    <= wgId;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wgDoneValid <= 1'b0;
      wgDoneId    <= '0;
    end else begin
      wgDoneValid <= groupDone;
      if (groupDone) begin
        wgDoneId <= grpId[endGroup];
      end
    end
  end

  // ==========================================================================
  // wavefront table
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waveValid  <= '0;
      waveParked <= '0;
      for (int i = 0; i < MAX_WAVES; i++) begin
        waveTimer[i] <= '0;
        waveGroup[i] <= '0;
      end
    end else begin
      if (memRespValid) begin
        waveParked[memRespSlot] <= 1'b0;
      end
      if (memPark) begin
        waveParked[curSlot] <= 1'b1;
      end
      if (waveEnd) begin
        waveValid[curSlot] <= 1'b0;
      end
      for (int i = 0; i < MAX_WAVES; i++) begin
        if (newWave[i]) begin
          waveValid[i]  <= 1'b1;
          waveParked[i] <= 1'b0;
          waveGroup[i]  <= newGroup;
        end
        // a reused slot keeps the gap after its last start
        if (issueStart && (curSlot == SLOT_W'(i))) begin
          waveTimer[i] <= TIMER_LOAD;
        end else if (waveTimer[i] != '0) begin
          waveTimer[i] <= waveTimer[i] - 3'h1;
        end
      end
    end
  end

  // ==========================================================================
  // issue sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state        <= ST_IDLE;
      curSlot      <= '0;
      issueQuarter <= '0;
      issueStart   <= 1'b0;
    end else if (advance) begin
      issueQuarter <= '0;
      if (pick[SLOT_W]) begin
        state      <= ST_BURST;
        curSlot    <= pick[SLOT_W-1:0];
        issueStart <= 1'b1;
      end else begin
        state      <= ST_IDLE;
        issueStart <= 1'b0;
      end
    end else begin
      issueQuarter <= issueQuarter + 2'h1;
      issueStart   <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      curKind <= KIND_ALU;
    end else if (issueStart) begin
      curKind <= instKind;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      issueRegRows  <= '0;
      issueTempBase <= '0;
    end else if (advance && pick[SLOT_W]) begin
      issueRegRows  <= grpRows[waveGroup[pick[SLOT_W-1:0]]];
      issueTempBase <= {pick[SLOT_W-1:0], 2'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memReqValid <= 1'b0;
      memReqSlot  <= '0;
    end else begin
      memReqValid <= memPark;
      if (memPark) begin
        memReqSlot <= curSlot;
      end
    end
  end

  assign issueValid    = (state == ST_BURST);
  assign issueSlot     = curSlot;
  assign issueLaneBase = {issueQuarter, 4'h0};
  assign issueLaneMask = {LANES{issueValid}};
endmodule : was_scheduler

// ==== tb/was_asserts.sv ====
`timescale 1ns/1ns
module was_asserts #(
  parameter int GLOBAL_LIMIT = was_pkg::GLOBAL_WAVE_LIMIT
) (
  // clock and reset
  input wire logic                            clk,
  input wire logic                            reset_n,
  // admission and completion
  input wire logic                            wgValid,
  input wire logic                            wgReady,
  input wire logic [was_pkg::WAVES_W-1:0]     wgWaves,
  input wire logic [was_pkg::CHIP_W-1:0]      otherWaves,
  input wire logic                            wgDoneValid,
  // issue
  input wire logic                            issueValid,
  input wire logic                            issueStart,
  input wire logic [was_pkg::SLOT_W-1:0]      issueSlot,
  input wire logic [1:0]                      issueQuarter,
  input wire logic [5:0]                      issueLaneBase,
  input wire logic [was_pkg::LANES-1:0]       issueLaneMask,
  input wire logic [was_pkg::SLOT_W+1:0]      issueTempBase,
  input wire was_pkg::was_kind_type           instKind,
  // memory path and occupancy
  input wire logic                            memReqValid,
  input wire logic [was_pkg::SLOT_W-1:0]      memReqSlot,
  input wire logic                            memRespValid,
  input wire logic [was_pkg::SLOT_W-1:0]      memRespSlot,
  input wire logic [was_pkg::CNT_W-1:0]       activeWaves,
  input wire logic [was_pkg::GCNT_W-1:0]      residentGroups
);
  import was_pkg::*;
  // ==========================================================================
  // parked slots seen on the memory path
  logic [MAX_WAVES-1:0] parked;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      parked <= '0;
    end else begin
      if (memRespValid) parked[memRespSlot] <= 1'b0;
      if (memReqValid) parked[memReqSlot] <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // assertions
  a_burst_quarters: assert property (issueStart |->
    issueValid && issueQuarter == 2'h0 ##1 issueValid && issueQuarter == 2'h1
    && $stable(issueSlot) ##1 issueValid && issueQuarter == 2'h2 && $stable(issueSlot)
    ##1 issueValid && issueQuarter == 2'h3 && $stable(issueSlot))
    else $error("burst is not four quarters of one slot");
  a_lane_quarter: assert property (
    issueLaneMask == {LANES{issueValid}}
    && (!issueValid || issueLaneBase == {issueQuarter, 4'h0}))
    else $error("lane mask or base wrong");
  a_dep_gap: assert property (issueStart |->
    !($past(issueStart, 4) && issueSlot == $past(issueSlot, 4))
    && !($past(issueStart, 5) && issueSlot == $past(issueSlot, 5))
    && !($past(issueStart, 6) && issueSlot == $past(issueSlot, 6))
    && !($past(issueStart, 7) && issueSlot == $past(issueSlot, 7)))
    else $error("same slot restarted within eight cycles");
  a_switch_after: assert property (
    issueValid && issueQuarter == 2'h3 |=> issueStart || !issueValid)
    else $error("no clean switch after quarter three");
  a_mem_request: assert property (
    issueStart && instKind == KIND_MEM_READ |-> ##4 memReqValid
    && memReqSlot == $past(issueSlot, 4))
    else $error("memory request missing or wrong slot");
  a_parked_idle: assert property (
    issueStart |-> !parked[issueSlot])
    else $error("parked slot issued");
  a_resident_caps: assert property (
    residentGroups <= MAX_GROUPS && activeWaves <= MAX_WAVES)
    else $error("resident counts above cap");
  a_ready_limits: assert property (wgReady |->
    residentGroups < MAX_GROUPS && wgWaves inside {[1:MAX_WG_WAVES]}
    && int'(otherWaves) + int'(activeWaves) + int'(wgWaves) <= GLOBAL_LIMIT)
    else $error("ready while a limit is exceeded");
  a_admit_count: assert property (
    wgValid && wgReady && !(issueValid && issueQuarter == 2'h3)
    |=> activeWaves == $past(activeWaves) + $past(wgWaves))
    else $error("admitted waves not counted");
  a_done_pulse: assert property (wgDoneValid |=> !wgDoneValid)
    else $error("completion pulse too long");
  a_temp_base: assert property (
    issueValid |-> issueTempBase == {issueSlot, 2'b00})
    else $error("clause temporary base wrong");
  c_admit: cover property (wgValid && wgReady);
  c_mem_round: cover property (memReqValid ##[1:700] memRespValid);
  c_done: cover property (wgDoneValid);
endmodule : was_asserts

bind was_scheduler was_asserts #(.GLOBAL_LIMIT(GLOBAL_LIMIT)) u_asserts (.*);

// ==== tb/was_mem_model.sv ====
`timescale 1ns/1ns
module was_mem_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // read requests
  input  wire logic                       memReqValid,
  input  wire logic [was_pkg::SLOT_W-1:0] memReqSlot,
  // completions
  output logic                            memRespValid,
  output logic      [was_pkg::SLOT_W-1:0] memRespSlot
);
  import was_pkg::*;
  logic [SLOT_W-1:0] slotQ[$];
  int dueQ[$];
  int cyc = 0;
  int due = 0;
  initial begin
    memRespValid = 1'b0;
    memRespSlot = '0;
  end
  // ==========================================================================
  // off-chip latency, answers in request order
  always @(posedge clk) begin
    if (!reset_n) begin
      slotQ.delete();
      dueQ.delete();
    end else if (memReqValid) begin
      due = cyc + $urandom_range(MEM_LAT_MAX_CYC, MEM_LAT_MIN_CYC);
      slotQ.push_back(memReqSlot);
      dueQ.push_back(due);
    end
    if (reset_n && dueQ.size() > 0 && cyc >= dueQ[0]) begin
      memRespValid <= 1'b1;
      memRespSlot <= slotQ.pop_front();
      void'(dueQ.pop_front());
    end else begin
      memRespValid <= 1'b0;
      memRespSlot <= ~memRespSlot;
    end
    cyc++;
  end
endmodule : was_mem_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import was_pkg::*;
  localparam int GLIM = 496;
  // ==========================================================================
  // design signals
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              wgValid = 1'b0;
  logic [WAVES_W-1:0] wgWaves = 3'h1;
  logic [ROWS_W-1:0] wgRegs = 8'h01;
  logic [LOC_W-1:0]  wgLocalBytes = 16'h0000;
  logic [7:0]        wgId = 8'h00;
  logic [CHIP_W-1:0] otherWaves = 10'h000;
  was_kind_type      instKind = KIND_ALU;
  logic wgReady, wgDoneValid, issueValid, issueStart, memReqValid, memRespValid;
  logic [7:0] wgDoneId;
  logic [SLOT_W-1:0] issueSlot, memReqSlot, memRespSlot;
  logic [1:0] issueQuarter;
  logic [5:0] issueLaneBase;
  logic [LANES-1:0] issueLaneMask;
  logic [ROWS_W-1:0] issueRegRows;
  logic [SLOT_W+1:0] issueTempBase;
  logic [CNT_W-1:0] activeWaves;
  logic [GCNT_W-1:0] residentGroups;
  // ==========================================================================
  // reference model state
  int badCount = 0;
  int checks = 0;
  int mg = 0, mw = 0, mr = 0, ml = 0, rowsExp = 0, o = 0;
  int doneN = 0, doneSum = 0, expN = 0, expSum = 0;
  bit draining = 1'b0;
  int regsTab [5] = '{30, 62, 124, 0, 7};

  always #5 clk = ~clk;
  was_scheduler #(.GLOBAL_LIMIT(GLIM), .WG_ID_W(8)) DUT (.*);
  was_mem_model u_mem (.*);

  always @(posedge clk)
    instKind <= draining ? KIND_END : ($urandom_range(3, 0) == 0 ? KIND_MEM_READ : KIND_ALU);

  always @(negedge clk) begin
    if (wgDoneValid === 1'b1) begin
      doneN++;
      doneSum += wgDoneId;
    end
    if (issueStart === 1'b1 && rowsExp > 0) cmp_val("rows", issueRegRows, rowsExp);
  end
  // ==========================================================================
  // compare, model and run control
  task automatic cmp_bit(string what, logic got, logic exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_val(string what, logic [15:0] got, int exp);
    checks++;
    if (got !== 16'(exp)) begin
      badCount++;
      $display("Error at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  function automatic bit fits(int w, int r, int l, int ow);
    int rr;
    rr = (r == 0) ? 1 : r;
    return w >= 1 && w <= MAX_WG_WAVES && mg < MAX_GROUPS && ow + mw + w <= GLIM
      && mr + rr * w <= ROW_CAP && ml + l <= LOCAL_BYTES;
  endfunction : fits

  task automatic offer(int w, int r, int l, int ow);
    bit e;
    @(posedge clk);
    wgWaves <= 3'(w);
    wgRegs <= 8'(r);
    wgLocalBytes <= 16'(l);
    otherWaves <= 10'(ow);
    @(negedge clk);
    e = fits(w, r, l, ow);
    cmp_bit("ready", wgReady, e);
    if (e) begin
      @(posedge clk);
      wgValid <= 1'b1;
      @(posedge clk);
      wgValid <= 1'b0;
      wgId <= wgId + 8'h01;
      mg++;
      mw += w;
      mr += ((r == 0) ? 1 : r) * w;
      ml += l;
      expN++;
      expSum += wgId;
      @(negedge clk);
      cmp_val("waves", activeWaves, mw);
      cmp_val("groups", residentGroups, mg);
    end
  endtask : offer

  task automatic drain();
    int n;
    draining = 1'b1;
    n = 0;
    while (n < 8000 && !(residentGroups === 4'h0 && activeWaves === 6'h00)) begin
      @(negedge clk);
      n++;
    end
    if (n == 8000) begin
      badCount++;
      $display("Error at %0t: drain timed out", $time);
      conclude();
    end
    repeat (4) @(negedge clk);
    cmp_val("done count", doneN, expN);
    cmp_val("done ids", doneSum, expSum);
    cmp_bit("idle", issueValid, 1'b0);
    mg = 0; mw = 0; mr = 0; ml = 0;
    doneN = 0; doneSum = 0; expN = 0; expSum = 0;
    draining = 1'b0;
  endtask : drain
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h410A));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    cmp_val("waves", activeWaves, 0);
    cmp_bit("ready", wgReady, 1'b1);
    cmp_bit("issue", issueValid, 1'b0);
    for (int t = 0; t < 5; t++) begin
      rowsExp = (regsTab[t] == 0) ? 1 : regsTab[t];
      for (int k = 0; k < 30; k++) begin
        o = (t >= 3) ? GLIM - mw - int'($urandom_range(4, 0)) : int'($urandom_range(400, 0));
        offer($urandom_range(5, 0), regsTab[t], $urandom_range(9000, 0), o);
      end
      if (t == 0) cmp_bit("thirty regs cap", activeWaves <= 6'h08, 1'b1);
      drain();
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule : testbench
